//--- hdl/chgsup_defines.svh
// Constants for the charge supervisor: offsets, fields, reset values, timing
//
// What this block does
// RULE1 - Charge only while thermistor sits between coldest and hottest limits; else suspend.
// RULE2 - Cool zone cuts charge current, down to 20% when selected.
// RULE3 - Warm zone regulates at programmed voltage or 4.1V per select bit.
// RULE4 - Charge termination inhibited in cool or warm zone.
// RULE5 - Boost outside thermistor window: suspend, bus status 000, thermistor fault.
// RULE6 - Safety timer limit 2 hours below low-battery level, else programmed length.
// RULE7 - Timer expiry sets charge fault 11 and raises an interrupt.
// RULE8 - Clearing timer enable stops the safety timer completely.
// RULE9 - Timer runs half rate in input limiting, cool cut or thermal regulation.
// RULE10 - Slowdown enable at 0 keeps the timer at full rate.
// RULE11 - Timer holds its count during a fault and resumes afterwards.
// RULE12 - Stopping and restarting charge, by pin or bit, resets the timer.
// RULE13 - System minimum flag follows system floor regulation.
// RULE14 - Input voltage and input current limit flags follow limiting.
// RULE15 - Switch off request opens the battery switch now or after ship delay.
// RULE16 - Ship mode exits on adapter, request clear, register reset or button press.
// RULE17 - Button ship exit also sets input float enable.
// RULE18 - No boost while input float is enabled.
// RULE19 - Button held for hold time, no adapter, switch on: open switch briefly.
// RULE20 - Button reset ignored while button reset enable is 0.
// RULE21 - An interrupt event seen while no pulse runs gives one active-low pulse of 256 us.
// RULE22 - Deglitch, hold, reset and ship delays are clock counters that restart.
`ifndef CHGSUP_DEFINES_SVH
`define CHGSUP_DEFINES_SVH

// ==========================================================================
// Register map
`define CS_ADDR_CTRL     12'h000
`define CS_ADDR_STATUS   12'h004
`define CS_ADDR_TIMER    12'h008

// ==========================================================================
// Control register fields
`define CS_CTRL_CHG_ALLOW   0
`define CS_CTRL_TMR_EN      1
`define CS_CTRL_SLOW_EN     2
`define CS_CTRL_LEN_LO      3
`define CS_CTRL_LEN_HI      4
`define CS_CTRL_WARM_SEL    5
`define CS_CTRL_COOL_SEL    6
`define CS_CTRL_OFF_REQ     7
`define CS_CTRL_DLY_SEL     8
`define CS_CTRL_BTN_RST_EN  9
`define CS_CTRL_FLOAT_EN    10
`define CS_CTRL_BOOST_EN    11
`define CS_CTRL_REG_RST     31
`define CS_CTRL_RESET       32'h0000_020f
`define CS_CTRL_MASK        32'h0000_0fff

// ==========================================================================
// Pin synchroniser layout and reset value (active-low pins idle high)
`define CS_SYNC_W     14
`define CS_SYNC_RST   14'h3000

// ==========================================================================
// Timing: clock, timer tick, hours and fixed limits
`define CS_CLK_MHZ        125
`define CS_TICK_US        1000
`define CS_MS_PER_HOUR    27'd3600000
`define CS_LOWV_HOURS     27'd2
`define CS_LEN0_HOURS     27'd5
`define CS_LEN1_HOURS     27'd10
`define CS_LEN2_HOURS     27'd15
`define CS_LEN3_HOURS     27'd20
`define CS_INT_PULSE_US   256
`define CS_DEGLITCH_US    1000
`define CS_RST_HOLD_US    8000000
`define CS_RST_DUR_US     250000
`define CS_SHIP_DLY_US    10000000

`endif

//--- hdl/chgsup_pkg.sv
// Types shared by the charge supervisor
`default_nettype none
package chgsup_pkg;
	// Battery switch control states
	typedef enum logic [1:0] {
		CS_SW_ON    = 2'b00,
		CS_SW_DELAY = 2'b01,
		CS_SW_SHIP  = 2'b10,
		CS_SW_RESET = 2'b11
	} chgsup_sw_t;
	// AXI response codes
	typedef enum logic [1:0] {
		CS_RESP_OKAY   = 2'b00,
		CS_RESP_SLVERR = 2'b10
	} chgsup_resp_t;
endpackage
`default_nettype wire

//--- hdl/chgsup_top.sv
// Charge supervisor: temperature qualification, safety timer, ship mode
`include "chgsup_defines.svh"
`default_nettype none
module chgsup_top #(
	parameter int unsigned TICK_CYCLES  = `CS_TICK_US * `CS_CLK_MHZ,
	parameter int unsigned INT_CYCLES   = `CS_INT_PULSE_US * `CS_CLK_MHZ,
	parameter int unsigned DEGL_CYCLES  = `CS_DEGLITCH_US * `CS_CLK_MHZ,
	parameter int unsigned HOLD_CYCLES  = `CS_RST_HOLD_US * `CS_CLK_MHZ,
	parameter int unsigned RDUR_CYCLES  = `CS_RST_DUR_US * `CS_CLK_MHZ,
	parameter int unsigned SDLY_CYCLES  = `CS_SHIP_DLY_US * `CS_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address and data
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Analog comparator and board pins (asynchronous)
	input  wire logic        chargeEnablePin_n,
	input  wire logic        push_button_pin_n,
	input  wire logic        tsBelowCold,
	input  wire logic        tsCoolZone,
	input  wire logic        tsWarmZone,
	input  wire logic        tsAboveHot,
	input  wire logic        boostWindowOk,
	input  wire logic        batteryLow,
	input  wire logic        inputVoltageLimiting,
	input  wire logic        inputCurrentLimiting,
	input  wire logic        thermalRegulating,
	input  wire logic        systemAtFloor,
	input  wire logic        adapterPresent,
	input  wire logic        chargeFaultPresent,
	input  wire logic [2:0]  busTypeDetected,
	// Regulation and switch controls
	output logic             chargeRun,
	output logic             coolCurrentCut,
	output logic             coolCurrentTwentyPct,
	output logic             warmVoltageCut,
	output logic             terminationInhibit,
	output logic             boostRun,
	output logic             batterySwitchOn,
	output logic             hostIntPin_n
);
	// ======================================================================
	// Pin synchroniser: first stage is read only by the second
	logic [`CS_SYNC_W-1:0] syncA;
	logic [`CS_SYNC_W-1:0] syncB;
	logic [2:0]            busTypeA;
	logic [2:0]            busType;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			syncA    <= `CS_SYNC_RST;
			syncB    <= `CS_SYNC_RST;
			busTypeA <= 3'h0;
			busType  <= 3'h0;
		end else begin
			syncA    <= {chargeEnablePin_n, push_button_pin_n, tsBelowCold, tsCoolZone,
				tsWarmZone, tsAboveHot, boostWindowOk, batteryLow, inputVoltageLimiting,
				inputCurrentLimiting, thermalRegulating, systemAtFloor, adapterPresent,
				chargeFaultPresent};
			syncB    <= syncA;
			busTypeA <= busTypeDetected;
			busType  <= busTypeA;
		end
	end

	// Named views of the synchronised pins
	wire ceN       = syncB[13];
	wire btnN      = syncB[12];
	wire zCold     = syncB[11];
	wire zCool     = syncB[10];
	wire zWarm     = syncB[9];
	wire zHot      = syncB[8];
	wire bstOk     = syncB[7];
	wire vLow      = syncB[6];
	wire vinLim    = syncB[5];
	wire iinLim    = syncB[4];
	wire thermReg  = syncB[3];
	wire sysFloor  = syncB[2];
	wire adapter   = syncB[1];
	wire faultIn   = syncB[0];

	// ======================================================================
	// AXI4-Lite slave: address and data taken in either order
	logic [31:0] ctrl;
	logic [11:0] awLatch;
	logic [31:0] wLatch;
	logic [3:0]  sLatch;
	logic        awHave;
	logic        wHave;
	logic [26:0] tmrCount;
	logic        tmrFault;
	logic        thermFault;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	wire doWrite   = awHave && wHave && !bvalid;
	wire wrCtrl    = doWrite && (awLatch[11:2] == `CS_ADDR_CTRL >> 2);
	wire wrMapped  = wrCtrl || (awLatch[11:2] == `CS_ADDR_STATUS >> 2)
		|| (awLatch[11:2] == `CS_ADDR_TIMER >> 2);
	wire [31:0] wrWord   = laneMerge(ctrl, wLatch, sLatch);
	wire        regReset = wrCtrl && wrWord[`CS_CTRL_REG_RST];
	wire doRead    = arvalid && arready;
	assign awready = !awHave;
	assign wready  = !wHave;
	assign arready = !rvalid;

	// Status word assembled from live state
	logic [2:0]  busField;
	chgsup_pkg::chgsup_sw_t swState;
	wire [31:0] statusWord = {15'h0000, swState, batterySwitchOn, boostRun, tmrFault, tmrFault,
		thermFault, busField, iinLim, vinLim, sysFloor, terminationInhibit, warmVoltageCut,
		coolCurrentCut, chargeRun}; // RULE13 RULE14
	wire [31:0] rdWord =
		(araddr[11:2] == `CS_ADDR_CTRL >> 2)   ? (ctrl & `CS_CTRL_MASK) :
		(araddr[11:2] == `CS_ADDR_STATUS >> 2) ? statusWord :
		(araddr[11:2] == `CS_ADDR_TIMER >> 2)  ? {5'h00, tmrCount} : 32'h0000_0000;
	wire rdMapped  = (araddr[11:2] == `CS_ADDR_CTRL >> 2)
		|| (araddr[11:2] == `CS_ADDR_STATUS >> 2) || (araddr[11:2] == `CS_ADDR_TIMER >> 2);

	// Write channel bookkeeping
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awHave  <= 1'b0;
			wHave   <= 1'b0;
			awLatch <= 12'h000;
			wLatch  <= 32'h0000_0000;
			sLatch  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= chgsup_pkg::CS_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHave  <= 1'b1;
				awLatch <= awaddr;
			end else if (doWrite) begin
				awHave <= 1'b0;
			end
			if (wvalid && wready) begin
				wHave  <= 1'b1;
				wLatch <= wdata;
				sLatch <= wstrb;
			end else if (doWrite) begin
				wHave <= 1'b0;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= wrMapped ? chgsup_pkg::CS_RESP_OKAY : chgsup_pkg::CS_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= chgsup_pkg::CS_RESP_OKAY;
		end else if (doRead) begin
			rvalid <= 1'b1;
			rdata  <= rdWord;
			rresp  <= rdMapped ? chgsup_pkg::CS_RESP_OKAY : chgsup_pkg::CS_RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// Control register with hardware updates from the switch logic
	logic btnExit;
	logic autoExit;
	logic [31:0] next_ctrl;
	always_comb begin
		next_ctrl = ctrl;
		if (autoExit) begin
			next_ctrl[`CS_CTRL_OFF_REQ] = 1'b0;
		end
		if (btnExit) begin
			next_ctrl[`CS_CTRL_FLOAT_EN] = 1'b1; // RULE17
		end
		// Software write wins; register reset restores every field
		if (regReset) begin
			next_ctrl = `CS_CTRL_RESET;
		end else if (wrCtrl) begin
			next_ctrl = wrWord & `CS_CTRL_MASK;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `CS_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ======================================================================
	// Temperature qualification and regulation selects
	wire chgEnable  = ctrl[`CS_CTRL_CHG_ALLOW] && !ceN;
	wire tempOk     = !zCold && !zHot; // RULE1
	wire offReq     = ctrl[`CS_CTRL_OFF_REQ];
	assign chargeRun            = chgEnable && tempOk && !tmrFault && !offReq; // RULE1
	assign coolCurrentCut       = chargeRun && zCool; // RULE2
	assign coolCurrentTwentyPct = coolCurrentCut && ctrl[`CS_CTRL_COOL_SEL]; // RULE2
	assign warmVoltageCut       = chargeRun && zWarm && ctrl[`CS_CTRL_WARM_SEL]; // RULE3
	assign terminationInhibit   = zCool || zWarm; // RULE4

	// ======================================================================
	// Boost qualification; float mode blocks boost outright
	wire boostReq = ctrl[`CS_CTRL_BOOST_EN] && !ctrl[`CS_CTRL_FLOAT_EN]; // RULE18
	assign boostRun = boostReq && bstOk; // RULE5
	assign busField = !boostReq ? busType : (bstOk ? 3'b111 : 3'b000); // RULE5
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			thermFault <= 1'b0;
		end else begin
			thermFault <= boostReq && !bstOk; // RULE5
		end
	end

	// ======================================================================
	// Safety timer: millisecond ticks, half rate under regulation
	logic [31:0] tickCnt;
	logic        halfPhase;
	logic        chgEnPrev;
	wire tick       = (tickCnt == TICK_CYCLES - 1);
	wire slowCond   = vinLim || iinLim || coolCurrentCut || thermReg; // RULE9
	wire halfRate   = ctrl[`CS_CTRL_SLOW_EN] && slowCond; // RULE10
	wire restart    = chgEnable && !chgEnPrev; // RULE12
	wire tmrEn      = ctrl[`CS_CTRL_TMR_EN];
	wire advance    = tick && chargeRun && !faultIn && (!halfRate || halfPhase); // RULE11
	logic [26:0] lenHours;
	always_comb begin
		case (ctrl[`CS_CTRL_LEN_HI:`CS_CTRL_LEN_LO])
			2'b00:   lenHours = `CS_LEN0_HOURS;
			2'b01:   lenHours = `CS_LEN1_HOURS;
			2'b10:   lenHours = `CS_LEN2_HOURS;
			default: lenHours = `CS_LEN3_HOURS;
		endcase
	end
	wire [26:0] limitMs = (vLow ? `CS_LOWV_HOURS : lenHours) * `CS_MS_PER_HOUR; // RULE6
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tickCnt   <= 32'h0000_0000;
			halfPhase <= 1'b0;
			chgEnPrev <= 1'b0;
		end else begin
			tickCnt   <= tick ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
			halfPhase <= tick ? !halfPhase : halfPhase;
			chgEnPrev <= chgEnable;
		end
	end
	// Count and expiry; a disabled timer neither counts nor faults
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmrCount <= 27'h0;
			tmrFault <= 1'b0;
		end else if (!tmrEn || restart) begin
			tmrCount <= 27'h0; // RULE8 RULE12
			tmrFault <= 1'b0;
		end else if (tmrCount >= limitMs) begin
			tmrFault <= 1'b1; // RULE7
		end else if (advance) begin
			tmrCount <= tmrCount + 27'h1;
		end
	end

	// ======================================================================
	// Host interrupt: one fixed-width low pulse per event seen while no pulse runs
	logic        tmrFaultPrev;
	logic        thermFaultPrev;
	logic [15:0] intCnt;
	wire intEvent = (tmrFault && !tmrFaultPrev) || (thermFault && !thermFaultPrev); // RULE7
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmrFaultPrev   <= 1'b0;
			thermFaultPrev <= 1'b0;
			intCnt         <= 16'h0000;
			hostIntPin_n   <= 1'b1;
		end else begin
			tmrFaultPrev   <= tmrFault;
			thermFaultPrev <= thermFault;
			if (intCnt != 16'h0000) begin
				intCnt       <= intCnt - 16'h0001;
				hostIntPin_n <= (intCnt == 16'h0001); // RULE21
			end else if (intEvent) begin
				intCnt       <= INT_CYCLES[15:0];
				hostIntPin_n <= 1'b0; // RULE21
			end
		end
	end

	// ======================================================================
	// Push-button low-time counter; restarts whenever the pin goes high
	logic [31:0] btnLowCnt;
	logic        btnArmed;
	wire btnDeglitched = !btnN && btnArmed && (btnLowCnt == DEGL_CYCLES - 1); // RULE16 RULE22
	wire btnHeld       = !btnN && (btnLowCnt == HOLD_CYCLES - 1); // RULE19 RULE22
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			btnLowCnt <= 32'h0000_0000;
			btnArmed  <= 1'b0;
		end else begin
			btnLowCnt <= btnN ? 32'h0000_0000 : btnLowCnt + {31'h0, ~&btnLowCnt};
			btnArmed  <= btnN ? 1'b1 : btnArmed; // high seen before the falling edge
		end
	end

	// ======================================================================
	// Battery switch state machine
	logic [31:0] swCnt;
	chgsup_pkg::chgsup_sw_t next_swState;
	wire btnResetOk = ctrl[`CS_CTRL_BTN_RST_EN] && !adapter && !offReq; // RULE20
	always_comb begin
		next_swState = swState;
		btnExit      = 1'b0;
		autoExit     = 1'b0;
		case (swState)
			chgsup_pkg::CS_SW_ON: begin
				if (offReq) begin
					next_swState = ctrl[`CS_CTRL_DLY_SEL] ? chgsup_pkg::CS_SW_DELAY
						: chgsup_pkg::CS_SW_SHIP; // RULE15
				end else if (btnHeld && btnResetOk) begin
					next_swState = chgsup_pkg::CS_SW_RESET; // RULE19
				end
			end
			chgsup_pkg::CS_SW_DELAY: begin
				if (!offReq) begin
					next_swState = chgsup_pkg::CS_SW_ON; // RULE22
				end else if (swCnt == SDLY_CYCLES - 1) begin
					next_swState = chgsup_pkg::CS_SW_SHIP; // RULE15
				end
			end
			chgsup_pkg::CS_SW_SHIP: begin
				if (!offReq || regReset) begin
					next_swState = chgsup_pkg::CS_SW_ON; // RULE16
				end else if (adapter || btnDeglitched) begin
					next_swState = chgsup_pkg::CS_SW_ON; // RULE16
					autoExit     = 1'b1;
					btnExit      = btnDeglitched && !adapter;
				end
			end
			chgsup_pkg::CS_SW_RESET: begin
				if (swCnt == RDUR_CYCLES - 1) begin
					next_swState = chgsup_pkg::CS_SW_ON; // RULE19
				end
			end
			default: next_swState = chgsup_pkg::CS_SW_ON;
		endcase
	end
	// State register and dwell counter; the counter restarts on every change
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			swState <= chgsup_pkg::CS_SW_ON;
			swCnt   <= 32'h0000_0000;
		end else begin
			swState <= next_swState;
			swCnt   <= (next_swState != swState) ? 32'h0000_0000 : swCnt + 32'h0000_0001;
		end
	end
	assign batterySwitchOn = (swState == chgsup_pkg::CS_SW_ON)
		|| (swState == chgsup_pkg::CS_SW_DELAY);
endmodule // chgsup_top
`default_nettype wire

//--- verification/chgsup_button_model.sv
// Push-button partner: pulled-up pin, pressed low for a given span
`default_nettype none
module chgsup_button_model (
	// Clock
	input wire logic clk,
	// Button pin, idle high through its pull-up
	output logic btn_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial btn_n = 1'b1;

	// Press for n cycles, then release back to the pull-up level
	task automatic press(input int n);
		@(posedge clk);
		btn_n <= 1'b0;
		repeat (n) @(posedge clk);
		btn_n <= 1'b1;
	endtask
endmodule // chgsup_button_model
`default_nettype wire

//--- verification/chgsup_sva.sv
// Port checker for the charge supervisor
`default_nettype none
module chgsup_sva #(
	parameter int unsigned INT_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic wvalid,
	input wire logic arvalid,
	input wire logic bvalid,
	input wire logic rvalid,
	// Sensor inputs
	input wire logic tsBelowCold,
	input wire logic tsCoolZone,
	input wire logic tsWarmZone,
	input wire logic tsAboveHot,
	input wire logic boostWindowOk,
	input wire logic adapterPresent,
	// Control outputs
	input wire logic chargeRun,
	input wire logic coolCurrentCut,
	input wire logic terminationInhibit,
	input wire logic boostRun,
	input wire logic batterySwitchOn,
	input wire logic hostIntPin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lowCnt;

	// Length of the current interrupt pulse so far
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) lowCnt <= 16'h0;
		else lowCnt <= hostIntPin_n ? 16'h0 : lowCnt + 16'h1;
	end

	// ======================================================================
	// Properties; pins pass two sync flops, so four stable samples suffice
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_chgWindow;
		(tsBelowCold || tsAboveHot) [*4] |-> !chargeRun;
	endproperty
	a_chgWindow: assert property (p_chgWindow) else $error("charge outside window");
	property p_coolCut;
		(tsCoolZone && chargeRun) [*4] |-> coolCurrentCut;
	endproperty
	a_coolCut: assert property (p_coolCut) else $error("no cool current cut");
	property p_termInh;
		(tsCoolZone || tsWarmZone) [*4] |-> terminationInhibit;
	endproperty
	a_termInh: assert property (p_termInh) else $error("termination not inhibited");
	property p_boostSusp;
		!boostWindowOk [*4] |-> !boostRun;
	endproperty
	a_boostSusp: assert property (p_boostSusp) else $error("boost outside window");
	property p_intPulse;
		$rose(hostIntPin_n) |-> lowCnt == INT_CYCLES[15:0];
	endproperty
	a_intPulse: assert property (p_intPulse) else $error("interrupt pulse length wrong");
	property p_adapterOn;
		adapterPresent [*6] |-> batterySwitchOn;
	endproperty
	a_adapterOn: assert property (p_adapterOn) else $error("switch open with adapter");
	property p_readCause;
		$rose(rvalid) |-> $past(arvalid);
	endproperty
	a_readCause: assert property (p_readCause) else $error("read data without request");
	property p_writeCause;
		$rose(bvalid) |-> $past(awvalid, 2) || $past(wvalid, 2);
	endproperty
	a_writeCause: assert property (p_writeCause) else $error("response without write");
endmodule // chgsup_sva

bind chgsup_top chgsup_sva #(.INT_CYCLES(INT_CYCLES)) i_sva (
	.clk(clk), .rstn(rstn), .awvalid(awvalid), .wvalid(wvalid), .arvalid(arvalid),
	.bvalid(bvalid), .rvalid(rvalid), .tsBelowCold(tsBelowCold), .tsCoolZone(tsCoolZone),
	.tsWarmZone(tsWarmZone), .tsAboveHot(tsAboveHot), .boostWindowOk(boostWindowOk),
	.adapterPresent(adapterPresent), .chargeRun(chargeRun), .coolCurrentCut(coolCurrentCut),
	.terminationInhibit(terminationInhibit), .boostRun(boostRun),
	.batterySwitchOn(batterySwitchOn), .hostIntPin_n(hostIntPin_n)
);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the charge supervisor
`include "chgsup_defines.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] RST = `CS_CTRL_RESET;
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, w;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [2:0] bus;
	logic ceN, btnN, tCold, tCool, tWarm, tHot, bwOk, batLow, vLim, iLim, thReg, sysFl, adapter, fault;
	logic chgRun, coolCut, cool20, warmCut, termInh, boostRun, swOn, intN;
	int n_fail, n_checks, d;

	// Design with shortened delays
	chgsup_top #(.TICK_CYCLES(10), .INT_CYCLES(20), .DEGL_CYCLES(8), .HOLD_CYCLES(40),
		.RDUR_CYCLES(16), .SDLY_CYCLES(32)) i_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .chargeEnablePin_n(ceN), .push_button_pin_n(btnN),
		.tsBelowCold(tCold), .tsCoolZone(tCool), .tsWarmZone(tWarm), .tsAboveHot(tHot),
		.boostWindowOk(bwOk), .batteryLow(batLow), .inputVoltageLimiting(vLim),
		.inputCurrentLimiting(iLim), .thermalRegulating(thReg), .systemAtFloor(sysFl),
		.adapterPresent(adapter), .chargeFaultPresent(fault), .busTypeDetected(bus),
		.chargeRun(chgRun), .coolCurrentCut(coolCut), .coolCurrentTwentyPct(cool20),
		.warmVoltageCut(warmCut), .terminationInhibit(termInh), .boostRun(boostRun),
		.batterySwitchOn(swOn), .hostIntPin_n(intN));
	chgsup_button_model i_btn (.clk(clk), .btn_n(btnN));

	// ======================================================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Waits end at a falling edge so outputs are settled
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// Bus write; handshakes judged at the falling edge, released after the rising one
	task automatic axw(input logic [11:0] a, input logic [31:0] dd);
		logic ad, wd, bd;
		@(posedge clk);
		awaddr <= a;
		wdata <= dd;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bd = 1'b0;
		while (!bd) begin
			@(negedge clk);
			ad = awvalid && awready;
			wd = wvalid && wready;
			bd = bvalid;
			r = bresp;
			@(posedge clk);
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a);
		logic ad, rd;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rd = 1'b0;
		while (!rd) begin
			@(negedge clk);
			ad = arvalid && arready;
			rd = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ad) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic rate();
		axr(`CS_ADDR_TIMER);
		w = v;
		wt(400);
		axr(`CS_ADDR_TIMER);
		d = int'(v - w);
	endtask
	task automatic btn_off(input int n);
		d = 0;
		fork
			i_btn.press(n);
			repeat (n + 40) begin
				@(negedge clk);
				if (swOn !== 1'b1) d++;
			end
		join
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_regs();
		axr(`CS_ADDR_CTRL);
		check(v, RST);
		axr(12'h0fc);
		check(r, chgsup_pkg::CS_RESP_SLVERR);
		axw(12'h0fc, 32'h0);
		check(r, chgsup_pkg::CS_RESP_SLVERR);
		wstrb <= 4'hc;
		axw(`CS_ADDR_CTRL, 32'h0);
		wstrb <= 4'hf;
		axr(`CS_ADDR_CTRL);
		check(v, RST);
	endtask
	task automatic t_status();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			iLim <= i == 2;
			vLim <= i == 1;
			sysFl <= i == 0;
			wt(4);
			axr(`CS_ADDR_STATUS);
			check(v[6:4], 1 << i);
		end
		{iLim, vLim, sysFl} <= 3'b000;
	endtask
	task automatic t_zones();
		tCool <= 1'b1;
		axw(`CS_ADDR_CTRL, RST | 32'h40);
		wt(4);
		w[0] = cool20;
		axw(`CS_ADDR_CTRL, RST);
		wt(4);
		check({w[0], cool20}, 2'b10);
		check({coolCut, termInh}, 2'b11);
		@(posedge clk);
		tCool <= 1'b0;
		tWarm <= 1'b1;
		axw(`CS_ADDR_CTRL, RST | 32'h20);
		wt(4);
		w[0] = warmCut;
		axw(`CS_ADDR_CTRL, RST);
		wt(4);
		check({w[0], warmCut}, 2'b10);
		check(termInh, 1);
		@(posedge clk);
		tWarm <= 1'b0;
		wt(4);
		check({warmCut, termInh, coolCut}, 3'b000);
	endtask
	task automatic t_timer();
		@(posedge clk);
		tHot <= 1'b1;
		wt(4);
		check(chgRun, 0);
		@(posedge clk);
		{tHot, tCold} <= 2'b01;
		wt(4);
		check(chgRun, 0);
		@(posedge clk);
		tCold <= 1'b0;
		wt(4);
		check(chgRun, 1);
		@(posedge clk);
		thReg <= 1'b1;
		rate();
		check(d inside {[19:22]}, 1);
		axw(`CS_ADDR_CTRL, RST & ~32'h4);
		rate();
		check(d inside {[39:42]}, 1);
		axw(`CS_ADDR_CTRL, RST);
		thReg <= 1'b0;
		fault <= 1'b1;
		wt(4);
		rate();
		check(d, 0);
		fault <= 1'b0;
		rate();
		check(d inside {[39:42]}, 1);
		ceN <= 1'b1;
		wt(4);
		@(posedge clk);
		ceN <= 1'b0;
		wt(4);
		axr(`CS_ADDR_TIMER);
		check(v < 3, 1);
		wt(100);
		axw(`CS_ADDR_CTRL, RST & ~32'h1);
		axw(`CS_ADDR_CTRL, RST);
		axr(`CS_ADDR_TIMER);
		check(v < 3, 1);
		axw(`CS_ADDR_CTRL, RST & ~32'h2);
		rate();
		check(v, 0);
		axw(`CS_ADDR_CTRL, RST);
	endtask
	task automatic t_boost();
		adapter <= 1'b0;
		axw(`CS_ADDR_CTRL, RST | 32'h800);
		wt(4);
		check(boostRun, 1);
		@(posedge clk);
		bwOk <= 1'b0;
		wt(4);
		check({boostRun, intN}, 2'b00);
		axr(`CS_ADDR_STATUS);
		check(v[10:7], 8);
		@(posedge clk);
		bwOk <= 1'b1;
		wt(4);
		check(boostRun, 1);
		axw(`CS_ADDR_CTRL, RST | 32'hc00);
		bus <= 3'h5;
		wt(4);
		check(boostRun, 0);
		axw(`CS_ADDR_CTRL, RST);
		axr(`CS_ADDR_STATUS);
		check(v[9:7], 5);
	endtask
	task automatic t_ship();
		axw(`CS_ADDR_CTRL, RST | 32'h80);
		wt(4);
		check(swOn, 0);
		i_btn.press(4);
		wt(4);
		check(swOn, 0);
		i_btn.press(20);
		wt(4);
		check(swOn, 1);
		axr(`CS_ADDR_CTRL);
		check({v[10], v[7]}, 2'b10);
		axw(`CS_ADDR_CTRL, RST | 32'h180);
		wt(20);
		check(swOn, 1);
		wt(30);
		check(swOn, 0);
		@(posedge clk);
		adapter <= 1'b1;
		wt(6);
		check(swOn, 1);
		@(posedge clk);
		adapter <= 1'b0;
		axw(`CS_ADDR_CTRL, RST | 32'h80);
		axw(`CS_ADDR_CTRL, RST);
		wt(4);
		check(swOn, 1);
		axw(`CS_ADDR_CTRL, RST | 32'h80);
		axw(`CS_ADDR_CTRL, 32'h8000_0000);
		wt(4);
		check(swOn, 1);
		axr(`CS_ADDR_CTRL);
		check(v, RST);
	endtask
	task automatic t_btnrst();
		btn_off(60);
		check(d, 16);
		btn_off(30);
		check(d, 0);
		axw(`CS_ADDR_CTRL, RST & ~32'h200);
		btn_off(60);
		check(d, 0);
		axw(`CS_ADDR_CTRL, RST);
		adapter <= 1'b1;
		btn_off(60);
		check(d, 0);
	endtask

	// ======================================================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#400000;
		n_fail++;
		close_out();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, rstn} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = {12'h0, 12'h0, 32'h0, 4'hf};
		{ceN, tCold, tCool, tWarm, tHot, batLow, vLim, iLim, thReg, sysFl, fault} = 11'h0;
		{bus, bwOk, adapter} = 5'h0b;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_status();
		t_zones();
		t_timer();
		t_boost();
		t_ship();
		t_btnrst();
		close_out();
	end
endmodule // testbench
`default_nettype wire
